// File: design/cog_params.svh
// constants for the clock output gating block
// assumes a 50 MHz ref_clk; times are held in microseconds
`ifndef COG_PARAMS_SVH
`define COG_PARAMS_SVH
`define COG_CLK_MHZ 50
`define COG_CYC(us) ((us) * `COG_CLK_MHZ)
`define COG_T_ON_XT_US 600
`define COG_T_OFF_US 400
`define COG_T_ON_HF_US 2500
`define COG_T_OLD_XH_US 350
`define COG_T_LOW_XH_US 2300
`define COG_T_OLD_HX_US 300
`define COG_T_LOW_HX_US 650
`define COG_T_STOP_SHORT_US 1400
`define COG_T_STOP_LONG_US 75000
`define COG_IRQ_DLY_TICKS 9'h0A0
`define COG_XT_BIT_1024 4
`define COG_XT_BIT_64 8
`define COG_XT_BIT_1 14
`define COG_HF_STEP 16'h0ABD
`define COG_SRC_XTAL 1'b0
`define COG_SEL_32K 2'h0
`define COG_TD_4096 2'h0
`endif

// File: design/cog_pkg.sv
// types shared by the clock output gating block
// no assumptions beyond a single clock domain
package cog_pkg;
   typedef enum logic [2:0] {
      ST_OFF, ST_ON, ST_RUN, ST_DRAIN, ST_OLD, ST_LOW, ST_SYNC
   } cog_state_t;

   typedef struct packed {
      logic directOutDisable;
      logic irqClockEnable;
      logic irqDelayEnable;
      logic offDelaySelect;
      logic offDelayEnable;
      logic sourceSelect;
      logic [1:0] xtalDividerSel;
      logic [12:0] hfDivider;
      logic [1:0] countdownClockSel;
   } cog_cfg_t;

   // one bit per wake source, also used for the mask set
   typedef struct packed {
      logic event_;
      logic alarm;
      logic countdown;
      logic update;
      logic tempHigh;
      logic tempLow;
   } cog_src_t;
endpackage : cog_pkg

// File: design/cog_clock_output_gating.sv
// square-wave output gating with interrupt wake and source switching
// assumes cfg, events and i2cStop come from ref_clk logic; xtalIn is the
// 32768 Hz oscillator pin and is synchronised here
`include "cog_params.svh"
`timescale 1ns/100ps
`default_nettype none
// Operation
// - direct enable drives wave continuously
// - disabled and no interrupt: pin low
// - masked source sets flag, starts wave
// - clearing enable keeps running flagged output
// - flag cleared: pin low unless direct
// - optional interrupt delay 1/256 to 3/512 s
// - delay only when disabled and masked
// - no delay for countdown at 4096 Hz
// - stop off-delay 1.4 ms or 75 ms
// - stop off-delay only when enabled
// - synchronous on/off, 1024 Hz within period
// - 32768 Hz: on 600 us, off 400 us
// - hf mode: on 2.5 ms, off 400 us
// - flag gating matches direct gating timing
// - xtal to hf: old, low 2.3 ms
// - hf to xtal: old, low, next edge
// - xtal divider change takes effect immediately
// - source select; hf is (n+1)*8192 Hz
// - xtal codes: 32k, 1024, 64, 1 Hz
// - oscillator stop freezes slow outputs
module cog_clock_output_gating #(
   parameter int ON_XT_CYC = `COG_CYC(`COG_T_ON_XT_US),
   parameter int ON_HF_CYC = `COG_CYC(`COG_T_ON_HF_US),
   parameter int OFF_CYC = `COG_CYC(`COG_T_OFF_US),
   parameter int OLD_XH_CYC = `COG_CYC(`COG_T_OLD_XH_US),
   parameter int LOW_XH_CYC = `COG_CYC(`COG_T_LOW_XH_US),
   parameter int OLD_HX_CYC = `COG_CYC(`COG_T_OLD_HX_US),
   parameter int LOW_HX_CYC = `COG_CYC(`COG_T_LOW_HX_US),
   parameter int STOP_SHORT_CYC = `COG_CYC(`COG_T_STOP_SHORT_US),
   parameter int STOP_LONG_CYC = `COG_CYC(`COG_T_STOP_LONG_US)
) (
   input wire logic ref_clk,
   input wire logic rst,
   input wire cog_pkg::cog_cfg_t cfg,
   input wire cog_pkg::cog_src_t clockMask,
   input wire cog_pkg::cog_src_t irqEvents,
   input wire logic irqFlagClear,
   input wire logic i2cStop,
   input wire logic oscStop,
   input wire logic xtalIn,
   output logic clockOutPin,
   output logic irqClockFlag,
   output logic irqOut
);
   import cog_pkg::*;

   localparam int TW = 22;

   cog_state_t state_r;
   logic [TW-1:0] timer_r;
   logic [TW-1:0] stopTmr_r;
   logic gate_r, srcAct_r, clockOut_r, flag_r, irq_r;
   logic xtS1_r, xtS2_r, xtD_r, waveD_r, holdArm_r, holdRun_r;
   logic dlyNeed_r, dlyWait_r;
   logic [8:0] dlyCnt_r;
   logic [14:0] xtCnt_r;
   logic [23:0] hfAcc_r;
   logic xtRise, xtWave, wave, rise, hit, enEff, timeUp;

   function automatic logic [TW-1:0] onDly(input logic src, input logic [1:0] sel);
      if (src != `COG_SRC_XTAL) onDly = TW'(ON_HF_CYC);
      else if (sel == `COG_SEL_32K) onDly = TW'(ON_XT_CYC);
      else onDly = '0;
   endfunction : onDly

   function automatic logic [TW-1:0] offDly(input logic src, input logic [1:0] sel);
      if (src != `COG_SRC_XTAL || sel == `COG_SEL_32K) offDly = TW'(OFF_CYC);
      else offDly = '0;
   endfunction : offDly

   // oscillator pin crossing
   always_ff @(posedge ref_clk or posedge rst) begin
      if (rst) begin
         xtS1_r <= 1'b0;
         xtS2_r <= 1'b0;
         xtD_r <= 1'b0;
      end else begin
         xtS1_r <= xtalIn;
         xtS2_r <= xtS1_r;
         xtD_r <= xtS2_r;
      end
   end
   assign xtRise = xtS2_r & ~xtD_r;

   // crystal prescaler; stop freezes only the divided taps
   always_ff @(posedge ref_clk or posedge rst) begin
      if (rst) xtCnt_r <= '0;
      else if (xtRise && !oscStop) xtCnt_r <= xtCnt_r + 15'h0001;
   end

   // hf synthesised by accumulator; above half the clock it aliases
   always_ff @(posedge ref_clk or posedge rst) begin
      if (rst) hfAcc_r <= '0;
      else hfAcc_r <= hfAcc_r + 24'((32'(cfg.hfDivider) + 32'h1) * `COG_HF_STEP);
   end

   always_comb begin
      case (cfg.xtalDividerSel)
         2'h0: xtWave = xtS2_r;
         2'h1: xtWave = xtCnt_r[`COG_XT_BIT_1024];
         2'h2: xtWave = xtCnt_r[`COG_XT_BIT_64];
         default: xtWave = xtCnt_r[`COG_XT_BIT_1];
      endcase
   end
   assign wave = (srcAct_r == `COG_SRC_XTAL) ? xtWave : hfAcc_r[23];
   assign rise = wave & ~waveD_r;
   assign hit = |(irqEvents & clockMask);
   assign timeUp = (timer_r == '0);

   always_ff @(posedge ref_clk or posedge rst) begin
      if (rst) waveD_r <= 1'b0;
      else waveD_r <= wave;
   end

   // clock flag; a new hit beats a clear in the same cycle
   always_ff @(posedge ref_clk or posedge rst) begin
      if (rst) flag_r <= 1'b0;
      else if (cfg.directOutDisable && cfg.irqClockEnable && hit) flag_r <= 1'b1;
      else if (irqFlagClear) flag_r <= 1'b0;
   end

   // off delay after bus stop keeps the output alive once the flag drops
   always_ff @(posedge ref_clk or posedge rst) begin
      if (rst) begin
         holdArm_r <= 1'b0;
         holdRun_r <= 1'b0;
         stopTmr_r <= '0;
      end else begin
         if (flag_r && irqFlagClear && !hit && cfg.offDelayEnable) holdArm_r <= 1'b1;
         else if (i2cStop || flag_r) holdArm_r <= 1'b0;
         if (holdArm_r && i2cStop) begin
            holdRun_r <= 1'b1;
            stopTmr_r <= cfg.offDelaySelect ? TW'(STOP_LONG_CYC) : TW'(STOP_SHORT_CYC);
         end else if (holdRun_r) begin
            if (stopTmr_r == '0 || flag_r) holdRun_r <= 1'b0;
            else stopTmr_r <= stopTmr_r - 1'b1;
         end
      end
   end

   assign enEff = ~cfg.directOutDisable | flag_r | holdArm_r | holdRun_r;

   // on, off and source switch sequencing
   always_ff @(posedge ref_clk or posedge rst) begin
      if (rst) begin
         state_r <= ST_OFF;
         timer_r <= '0;
         gate_r <= 1'b0;
         srcAct_r <= `COG_SRC_XTAL;
      end else begin
         if (!timeUp) timer_r <= timer_r - 1'b1;
         case (state_r)
            ST_OFF: begin
               gate_r <= 1'b0;
               if (enEff) begin
                  srcAct_r <= cfg.sourceSelect;
                  timer_r <= onDly(cfg.sourceSelect, cfg.xtalDividerSel);
                  state_r <= ST_ON;
               end
            end
            ST_ON: begin
               if (!enEff) state_r <= ST_OFF;
               else if (timeUp && rise) begin
                  gate_r <= 1'b1;
                  state_r <= ST_RUN;
               end
            end
            ST_RUN: begin
               if (!enEff) begin
                  timer_r <= offDly(srcAct_r, cfg.xtalDividerSel);
                  state_r <= ST_DRAIN;
               end else if (cfg.sourceSelect != srcAct_r) begin
                  timer_r <= (srcAct_r == `COG_SRC_XTAL) ? TW'(OLD_XH_CYC) : TW'(OLD_HX_CYC);
                  state_r <= ST_OLD;
               end
            end
            ST_DRAIN: begin
               if (enEff) state_r <= ST_RUN;
               else if (timeUp && !wave) begin
                  gate_r <= 1'b0;
                  state_r <= ST_OFF;
               end
            end
            ST_OLD: begin
               if (timeUp) begin
                  gate_r <= 1'b0;
                  timer_r <= (srcAct_r == `COG_SRC_XTAL) ? TW'(LOW_XH_CYC) : TW'(LOW_HX_CYC);
                  state_r <= ST_LOW;
               end
            end
            ST_LOW: begin
               if (timeUp) begin
                  srcAct_r <= cfg.sourceSelect;
                  if (cfg.sourceSelect == `COG_SRC_XTAL) state_r <= ST_SYNC;
                  else begin
                     gate_r <= 1'b1;
                     state_r <= ST_RUN;
                  end
               end
            end
            ST_SYNC: begin
               if (rise) begin
                  gate_r <= 1'b1;
                  state_r <= ST_RUN;
               end
            end
            default: state_r <= ST_OFF;
         endcase
      end
   end

   always_ff @(posedge ref_clk or posedge rst) begin
      if (rst) clockOut_r <= 1'b0;
      else clockOut_r <= gate_r & wave;
   end

   // interrupt to the mcu, optionally held back after the clock starts
   always_ff @(posedge ref_clk or posedge rst) begin
      if (rst) begin
         dlyNeed_r <= 1'b0;
         dlyWait_r <= 1'b0;
         dlyCnt_r <= '0;
         irq_r <= 1'b0;
      end else begin
         if (cfg.directOutDisable && cfg.irqClockEnable && hit && !irq_r && !dlyWait_r) begin
            // countdown at its fastest tick has no room for a delay
            dlyNeed_r <= cfg.irqDelayEnable &&
               (|(irqEvents & clockMask & ~6'h08) ||
                cfg.countdownClockSel != `COG_TD_4096);
            dlyWait_r <= 1'b1;
            dlyCnt_r <= '0;
         end else if (dlyWait_r) begin
            if (!dlyNeed_r) begin
               irq_r <= 1'b1;
               dlyWait_r <= 1'b0;
            end else if (dlyCnt_r == `COG_IRQ_DLY_TICKS) begin
               irq_r <= 1'b1;
               dlyWait_r <= 1'b0;
            end else if (gate_r && xtRise) dlyCnt_r <= dlyCnt_r + 9'h001;
         end else if (irqFlagClear) irq_r <= 1'b0;
      end
   end

   assign clockOutPin = clockOut_r;
   assign irqClockFlag = flag_r;
   assign irqOut = irq_r;

   property p_gate_low;
      @(posedge ref_clk) disable iff (rst) !gate_r |=> !clockOut_r;
   endproperty
   a_gate_low: assert property (p_gate_low) else $error("output not low when gated");

   property p_flag_set;
      @(posedge ref_clk) disable iff (rst)
         cfg.directOutDisable && cfg.irqClockEnable && hit |=> flag_r;
   endproperty
   a_flag_set: assert property (p_flag_set) else $error("flag not set");

   property p_flag_hold;
      @(posedge ref_clk) disable iff (rst) flag_r && !irqFlagClear |=> flag_r;
   endproperty
   a_flag_hold: assert property (p_flag_hold) else $error("flag dropped");

   property p_run_stay;
      @(posedge ref_clk) disable iff (rst)
         state_r == ST_RUN && !cfg.directOutDisable && cfg.sourceSelect == srcAct_r
         |=> state_r == ST_RUN && gate_r;
   endproperty
   a_run_stay: assert property (p_run_stay) else $error("direct output stopped");

   property p_drain_off;
      @(posedge ref_clk) disable iff (rst)
         state_r == ST_DRAIN && !enEff && timeUp && !wave |=> state_r == ST_OFF ##1 !clockOut_r;
   endproperty
   a_drain_off: assert property (p_drain_off) else $error("turn-off not synchronous");

   property p_old_low;
      @(posedge ref_clk) disable iff (rst)
         state_r == ST_OLD && timeUp |=> state_r == ST_LOW && !gate_r ##1 !clockOut_r;
   endproperty
   a_old_low: assert property (p_old_low) else $error("switch low phase missing");

   property p_sync_wait;
      @(posedge ref_clk) disable iff (rst)
         state_r == ST_SYNC && !rise |=> state_r == ST_SYNC && !gate_r;
   endproperty
   a_sync_wait: assert property (p_sync_wait) else $error("left sync before edge");

   property p_osc_freeze;
      @(posedge ref_clk) disable iff (rst) oscStop |=> $stable(xtCnt_r);
   endproperty
   a_osc_freeze: assert property (p_osc_freeze) else $error("prescaler ran while stopped");

   property p_no_delay;
      @(posedge ref_clk) disable iff (rst)
         dlyWait_r && !dlyNeed_r |=> irq_r;
   endproperty
   a_no_delay: assert property (p_no_delay) else $error("interrupt delayed wrongly");
endmodule : cog_clock_output_gating
`default_nettype wire

// File: testbench/cog_mcu_model.sv
// wake-up target model: a controller clocked by the gated output
// assumes ref_clk samples the pin fast enough to see each edge
`timescale 1ns/100ps
`default_nettype none
module cog_mcu_model (
   input wire logic ref_clk,
   input wire logic rst,
   input wire logic clockOutPin,
   input wire logic irqOut,
   input wire logic svcReq,
   input wire logic sleepReq,
   output logic irqFlagClear,
   output logic i2cStop
);
   logic [1:0] pinHist;
   logic [2:0] edgeCnt;
   // it only runs on its own clock, so service waits for pin edges
   always_ff @(posedge ref_clk or posedge rst) begin
      if (rst) begin
         pinHist <= '0;
         edgeCnt <= '0;
         irqFlagClear <= 1'b0;
         i2cStop <= 1'b0;
      end else begin
         pinHist <= {pinHist[0], clockOutPin};
         irqFlagClear <= 1'b0;
         i2cStop <= irqFlagClear & sleepReq;
         if (!svcReq || !irqOut) begin
            edgeCnt <= '0;
         end else if (pinHist == 2'b01) begin
            edgeCnt <= edgeCnt + 3'h1;
            if (edgeCnt == 3'h3) irqFlagClear <= 1'b1;
         end
      end
   end
endmodule : cog_mcu_model
`default_nettype wire

// File: testbench/tb.sv
// self-checking bench for the clock output gating block
// assumes shortened delays and a fast crystal stand-in
`timescale 1ns/100ps
`default_nettype none
module tb;
   import cog_pkg::*;
   localparam int OFF = 30;
   localparam int STOP_S = 100;
   localparam int STOP_L = 200;
   localparam int ON_XT = 40;
   localparam int ON_HF = 80;
   localparam int OLD_XH = 20;
   localparam int LOW_XH = 60;
   localparam int OLD_HX = 20;
   localparam int LOW_HX = 30;
   logic ref_clk, rst, oscStop, xtalIn, svcReq, sleepReq;
   logic irqFlagClear, i2cStop, clockOutPin, irqClockFlag, irqOut;
   cog_cfg_t cfg;
   cog_src_t clockMask, irqEvents;
   int miscompares = 0;
   int nChecks = 0;
   int rises, lowRun, gap, hfRises, firstRise, lastRise;
   int cycles = 0;
   logic gotQ[$];
   logic expQ[$];
   event resEv;
   cog_clock_output_gating #(.ON_XT_CYC(ON_XT), .ON_HF_CYC(ON_HF), .OFF_CYC(OFF),
      .OLD_XH_CYC(OLD_XH), .LOW_XH_CYC(LOW_XH), .OLD_HX_CYC(OLD_HX), .LOW_HX_CYC(LOW_HX),
      .STOP_SHORT_CYC(STOP_S), .STOP_LONG_CYC(STOP_L)) u_dut (.ref_clk, .rst,
      .cfg, .clockMask, .irqEvents, .irqFlagClear, .i2cStop, .oscStop,
      .xtalIn, .clockOutPin, .irqClockFlag, .irqOut);
   cog_mcu_model u_mcu (.ref_clk, .rst, .clockOutPin, .irqOut, .svcReq,
      .sleepReq, .irqFlagClear, .i2cStop);
   initial begin
      ref_clk = 0;
      forever #10 ref_clk = ~ref_clk;
   end
   // crystal stand-in far faster than 32768 Hz to keep the run short
   initial begin
      xtalIn = 0;
      forever #100 xtalIn = ~xtalIn;
   end
   task automatic chk(input logic got, input logic exp);
      nChecks++;
      if (got !== exp) begin
         miscompares++;
         $display("unexpected at %0t: saw %b, wanted %b", $time, got, exp);
      end
   endtask : chk
   task automatic ex(input logic got, input logic exp);
      gotQ.push_back(got);
      expQ.push_back(exp);
      ->resEv;
   endtask : ex
   always @(resEv) begin
      while (gotQ.size() > 0) chk(gotQ.pop_front(), expQ.pop_front());
   end
   task automatic printVerdict();
      $display("checks %0d, mismatches %0d", nChecks, miscompares);
      if (miscompares == 0 && nChecks > 0) begin
         $display("ALL CHECKS OK");
      end else begin
         $display("CHECKS NOT OK");
      end
      $finish;
   endtask : printVerdict
   always @(posedge ref_clk) begin
      cycles++;
      if (cycles == 40000) begin
         miscompares++;
         printVerdict();
      end
   end
   task automatic cyc(input int n);
      repeat (n) @(posedge ref_clk);
      #1;
   endtask : cyc
   task automatic watch(input int n);
      logic prev;
      int run;
      prev = clockOutPin;
      run = 0;
      firstRise = -1;
      lastRise = -1;
      rises = 0;
      lowRun = 0;
      for (int i = 0; i < n; i++) begin
         cyc(1);
         if (clockOutPin === 1'b1 && prev !== 1'b1) begin
            rises++;
            if (lastRise >= 0) gap = i - lastRise;
            if (firstRise < 0) firstRise = i;
            lastRise = i;
         end
         run = (clockOutPin === 1'b0) ? run + 1 : 0;
         if (run > lowRun) lowRun = run;
         prev = clockOutPin;
      end
   endtask : watch
   task automatic fire(input int b);
      irqEvents = cog_src_t'(6'(1 << b));
      cyc(1);
      irqEvents = '0;
   endtask : fire
   task automatic service(input logic slp);
      int k;
      svcReq = 1;
      sleepReq = slp;
      for (k = 0; k < 500 && irqClockFlag !== 1'b0; k++) cyc(1);
      svcReq = 0;
      ex(k < 500, 1);
   endtask : service
   initial begin
      rst = 1;
      cfg = '0;
      clockMask = '0;
      irqEvents = '0;
      oscStop = 0;
      svcReq = 0;
      sleepReq = 0;
      void'($urandom(32'h0ef74d3b));
      repeat (6) @(posedge ref_clk);
      #1 rst = 0;
      watch(200);
      ex(rises > 15, 1);
      cfg.xtalDividerSel = 2'h1;
      watch(700);
      ex(gap == 320, 1);
      oscStop = 1;
      watch(700);
      ex(rises == 0, 1);
      cfg.xtalDividerSel = 2'h0;
      watch(100);
      ex(rises > 5, 1);
      oscStop = 0;
      cfg.directOutDisable = 1;
      watch(OFF + 20);
      watch(300);
      ex(lowRun == 300, 1);
      $display("test direct done");
      cfg.irqClockEnable = 1;
      for (int b = 0; b < 6; b++) begin
         clockMask = cog_src_t'(6'(1 << b));
         fire((b + 1 + $urandom_range(0, 4)) % 6);
         cyc(1);
         ex(irqClockFlag, 0);
         fire(b);
         ex(irqClockFlag, 1);
         ex(irqOut, 0);
         cyc(1);
         ex(irqOut, 1);
         watch(100);
         ex(rises > 3, 1);
         ex(firstRise >= ON_XT && firstRise <= ON_XT + 12, 1);
         service(b[0]);
         watch(90);
         ex(lowRun > 40, 1);
         ex(irqOut, 0);
      end
      fire(5);
      cfg.irqClockEnable = 0;
      watch(100);
      ex(rises > 3, 1);
      service(0);
      fire(5);
      cyc(1);
      ex(irqClockFlag, 0);
      cfg.irqClockEnable = 1;
      $display("test wake done");
      cfg.irqDelayEnable = 1;
      clockMask = '0;
      clockMask.countdown = 1;
      fire(3);
      cyc(1);
      ex(irqOut, 1);
      service(0);
      cfg.countdownClockSel = 2'($urandom_range(1, 3));
      fire(3);
      cyc(1);
      ex(irqOut, 0);
      watch(1200);
      ex(irqOut, 0);
      for (int k = 0; k < 1000 && irqOut !== 1'b1; k++) cyc(1);
      ex(irqOut, 1);
      service(0);
      cfg.irqDelayEnable = 0;
      $display("test delay done");
      cfg.offDelayEnable = 1;
      clockMask = '0;
      clockMask.alarm = 1;
      for (int s = 0; s < 2; s++) begin
         cfg.offDelaySelect = s[0];
         fire(4);
         watch(100);
         service(1);
         watch(s ? STOP_L - 10 : STOP_S - 10);
         ex(lowRun < 15, 1);
         watch(OFF + 30);
         watch(100);
         ex(lowRun == 100, 1);
      end
      cfg.offDelayEnable = 0;
      $display("test stop done");
      cfg.hfDivider = 13'($urandom_range(200, 400));
      hfRises = 500 * (int'(cfg.hfDivider) + 1) * 8192 / 50000000;
      cfg.directOutDisable = 0;
      watch(150);
      cfg.sourceSelect = 1;
      watch(300);
      ex(lowRun >= LOW_XH && lowRun <= LOW_XH + 25, 1);
      watch(500);
      ex(rises >= hfRises - 2 && rises <= hfRises + 2, 1);
      cfg.directOutDisable = 1;
      watch(OFF + 40);
      ex(rises > 0 && lastRise <= OFF + 2, 1);
      watch(60);
      ex(lowRun == 60, 1);
      cfg.directOutDisable = 0;
      watch(ON_HF + 60);
      ex(firstRise >= ON_HF && firstRise <= ON_HF + 35, 1);
      cfg.sourceSelect = 0;
      watch(200);
      ex(lowRun >= LOW_HX && lowRun <= LOW_HX + 30, 1);
      $display("test source done");
      cyc(2);
      printVerdict();
   end
endmodule : tb
`default_nettype wire
